// file: verilog/vcfm_monitor.sv
// Notes on behaviour
// - Each code has one severity; E00 none.
// - Single deviating counter copy: warn, rewrite majority.
// - No two counter copies agree: alarm.
// - Parameter copy mismatch raises inconsistency alarm.
// - Default parameters at restart raise alarm.
// - Power loss: alarm, stamp times, stop measuring.
// - Card not addressable raises message.
// - Open calibration lock: allow edits, message.
// - Pulse card supply failure raises alarm.
// - Pulse rate above 1.8x limit alarms.
// - Enabled line-breakage detection raises warning.
// - Input deviation: lower one suspect, switch source.
// - Flow above 1.1x maximum raises alarm.
// - Run-up longer than configured period warns.
// - Run-down longer than configured period warns.
// - Eight-digit volume counter wraps, warns each wrap.
// - Interval counter overflow raises message.
// - Pressure current out of range: alarm, substitute.
// - Open lock masks current cause, not supply.
// - Pressure outside alarm band: fault, substitute, unless lock open.
// - Warning limits widened by half hysteresis.
module vcfm_monitor
   import vcfm_pkg::*;
#(
   parameter int FW = 16,
   parameter int TW = 24,
   parameter int PW = 16
) (
   // Clock and reset
   input  wire logic            i_clk,
   input  wire logic            i_sys_rst,
   // System status
   input  wire logic            i_default_params_loaded,
   input  wire logic            i_power_ok,
   input  wire logic [31:0]     i_time_now,
   input  wire logic            i_param_copy_mismatch,
   input  wire logic            i_card_addr_fail,
   input  wire logic            i_cal_lock_open,
   input  wire logic            i_ival_ovf,
   // Pulse inputs
   input  wire logic            i_pulse_supply_fail,
   input  wire logic            i_pulse1,
   input  wire logic            i_pulse2,
   input  wire logic            i_line_break1,
   input  wire logic            i_line_break2,
   input  wire logic            i_brk_mon_en1,
   input  wire logic            i_brk_mon_en2,
   input  wire logic [FW-1:0]   i_freq1,
   input  wire logic [FW-1:0]   i_freq2,
   input  wire logic [FW-1:0]   i_freq_qmax,
   input  wire logic [VCNT_W-1:0] i_dev_limit,
   // Flow
   input  wire logic [FW-1:0]   i_flow,
   input  wire logic [FW-1:0]   i_flow_max,
   input  wire logic [FW-1:0]   i_lower_flow_limit,
   input  wire logic [TW-1:0]   i_runup_period,
   input  wire logic [TW-1:0]   i_rundown_period,
   // Pressure
   input  wire logic [15:0]     i_p_current_ua,
   input  wire logic            i_p_supply_bad,
   input  wire logic [PW-1:0]   i_pressure,
   input  wire logic [PW-1:0]   i_p_alarm_lo,
   input  wire logic [PW-1:0]   i_p_alarm_hi,
   input  wire logic [PW-1:0]   i_p_warn_lo,
   input  wire logic [PW-1:0]   i_p_warn_hi,
   input  wire logic [PW-1:0]   i_p_hyst,
   input  wire logic [PW-1:0]   i_p_substitute,
   // Status outputs
   output logic [NUM_FLAGS-1:0] o_flags,
   output logic [7:0]           o_code,
   output logic [1:0]           o_severity,
   output logic [VCNT_W-1:0]    o_volume,
   output logic                 o_use_input2,
   output logic                 o_measure_en,
   output logic [31:0]          o_outage_start,
   output logic [31:0]          o_outage_end,
   output logic [PW-1:0]        o_pressure_used,
   output logic                 o_cal_write_en
);
   initial begin
      if (FW < 2 || TW < 2 || PW < 2) $error("vcfm_monitor: widths too small");
   end

   // ************************************
   // Input synchronisers
   // ************************************
   localparam int NS = 14;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   always_ff @(posedge i_clk) begin
      s1_reg <= {i_default_params_loaded, i_power_ok, i_param_copy_mismatch,
                 i_card_addr_fail, i_cal_lock_open, i_ival_ovf, i_pulse_supply_fail,
                 i_pulse1, i_pulse2, i_line_break1, i_line_break2, i_brk_mon_en1,
                 i_brk_mon_en2, i_p_supply_bad};
      s2_reg <= s1_reg;
   end
   logic dflt, pwr_ok, pmis, card, cal_open, ivovf, psup, p1, p2, lb1, lb2, en1, en2, psb;
   assign {dflt, pwr_ok, pmis, card, cal_open, ivovf, psup, p1, p2, lb1, lb2, en1, en2,
           psb} = s2_reg;

   // ************************************
   // Power loss and measurement gate
   // ************************************
   logic pwr_prev_reg;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pwr_prev_reg   <= 1'b1;
         o_outage_start <= 32'h0;
         o_outage_end   <= 32'h0;
      end else begin
         pwr_prev_reg <= pwr_ok;
         if (pwr_prev_reg && !pwr_ok) o_outage_start <= i_time_now;
         if (!pwr_prev_reg && pwr_ok) o_outage_end <= i_time_now;
      end
   end
   assign o_measure_en   = pwr_ok;
   assign o_cal_write_en = cal_open;

   // ************************************
   // Triplicated volume counter
   // ************************************
   logic [VCNT_W-1:0] cp_reg [3];
   logic [VCNT_W-1:0] major;
   logic [2:0]        bad;
   logic              none_agree;
   logic              p1_prev_reg;
   logic              p2_prev_reg;
   logic              use2_reg;
   logic              vol_tick;
   logic              wrap;

   vcfm_vote #(.W(VCNT_W)) u_vote (
      .i_cp0   (cp_reg[0]),
      .i_cp1   (cp_reg[1]),
      .i_cp2   (cp_reg[2]),
      .o_major (major),
      .o_bad   (bad),
      .o_none  (none_agree)
   );

   assign vol_tick = pwr_ok && (use2_reg ? (p2 && !p2_prev_reg) : (p1 && !p1_prev_reg));
   assign wrap     = vol_tick && (major == VCNT_MAX[VCNT_W-1:0]);

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_copy
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) cp_reg[g] <= VCNT_RESET[VCNT_W-1:0];
            else if (!none_agree) begin
               if (wrap) cp_reg[g] <= VCNT_RESET[VCNT_W-1:0];
               else if (vol_tick) cp_reg[g] <= major + 1'b1;
               else if (bad[g]) cp_reg[g] <= major;
            end
         end
      end
   endgenerate
   assign o_volume = major;

   // ************************************
   // Pulse input comparison
   // ************************************
   logic [VCNT_W-1:0] c1_reg;
   logic [VCNT_W-1:0] c2_reg;
   logic [VCNT_W-1:0] diff;
   assign diff = (c1_reg > c2_reg) ? c1_reg - c2_reg : c2_reg - c1_reg;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         p1_prev_reg <= 1'b0;
         p2_prev_reg <= 1'b0;
         c1_reg      <= '0;
         c2_reg      <= '0;
      end else begin
         p1_prev_reg <= p1;
         p2_prev_reg <= p2;
         if (pwr_ok && p1 && !p1_prev_reg) c1_reg <= c1_reg + 1'b1;
         if (pwr_ok && p2 && !p2_prev_reg) c2_reg <= c2_reg + 1'b1;
      end
   end
   logic dev_hit;
   assign dev_hit = diff > i_dev_limit;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) use2_reg <= 1'b0;
      else if (dev_hit) use2_reg <= (c1_reg < c2_reg);
   end
   assign o_use_input2 = use2_reg;

   // ************************************
   // Run-up and run-down timers
   // ************************************
   logic [TW-1:0] up_cnt_reg;
   logic [TW-1:0] dn_cnt_reg;
   logic          up_act_reg;
   logic          dn_act_reg;
   logic          below;
   logic          zero;
   logic          below_prev_reg;
   assign zero  = (i_flow == '0);
   assign below = (i_flow < i_lower_flow_limit);
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         up_act_reg     <= 1'b0;
         dn_act_reg     <= 1'b0;
         up_cnt_reg     <= '0;
         dn_cnt_reg     <= '0;
         below_prev_reg <= 1'b1;
      end else begin
         below_prev_reg <= below;
         if (zero) begin
            up_act_reg <= 1'b1;
            up_cnt_reg <= '0;
         end else if (!below) up_act_reg <= 1'b0;
         else if (up_act_reg && up_cnt_reg != '1) up_cnt_reg <= up_cnt_reg + 1'b1;
         if (below && !below_prev_reg && !zero) begin
            dn_act_reg <= 1'b1;
            dn_cnt_reg <= '0;
         end else if (zero || !below) dn_act_reg <= 1'b0;
         else if (dn_act_reg && dn_cnt_reg != '1) dn_cnt_reg <= dn_cnt_reg + 1'b1;
      end
   end

   // ************************************
   // Pressure checks
   // ************************************
   logic [PW:0] half_h;
   logic        cur_bad;
   logic        alm_band;
   logic        warn_lo;
   logic        warn_hi;
   assign half_h   = {1'b0, i_p_hyst} >> 1;
   assign cur_bad  = (i_p_current_ua < 16'(CUR_MIN_UA)) || (i_p_current_ua > 16'(CUR_MAX_UA));
   assign alm_band = (i_pressure < i_p_alarm_lo) || (i_pressure > i_p_alarm_hi);
   assign warn_lo  = ({1'b0, i_pressure} + half_h) < {1'b0, i_p_warn_lo};
   assign warn_hi  = {1'b0, i_pressure} > ({1'b0, i_p_warn_hi} + half_h);

   // ************************************
   // Condition vector
   // ************************************
   logic [NUM_FLAGS-1:0] cond;
   always_comb begin
      cond = '0;
      cond[F_NEW_START] = dflt;
      cond[F_PWR_FAIL]  = !pwr_ok;
      cond[F_INCONS]    = pmis || none_agree;
      cond[F_MEM_CMP]   = |bad;
      cond[F_CARD]      = card;
      cond[F_CAL_OPEN]  = cal_open;
      cond[F_CNT_SUP]   = psup;
      cond[F_FREQ1]     = (i_freq1 * LIM_DEN) > (i_freq_qmax * FREQ_LIM_NUM);
      cond[F_FREQ2]     = (i_freq2 * LIM_DEN) > (i_freq_qmax * FREQ_LIM_NUM);
      cond[F_BRK1]      = en1 && lb1;
      cond[F_BRK2]      = en2 && lb2;
      cond[F_SUS1]      = dev_hit && (c1_reg < c2_reg);
      cond[F_SUS2]      = dev_hit && (c2_reg < c1_reg);
      cond[F_QMAX]      = (i_flow * LIM_DEN) > (i_flow_max * FLOW_LIM_NUM);
      cond[F_RUNUP]     = up_act_reg && (up_cnt_reg > i_runup_period);
      cond[F_RUNDN]     = dn_act_reg && (dn_cnt_reg > i_rundown_period);
      cond[F_VOVF]      = wrap;
      cond[F_IVOVF]     = ivovf;
      cond[F_PMEAS]     = psb || (cur_bad && !cal_open);
      cond[F_PALM]      = alm_band && !cal_open;
      cond[F_PWLO]      = warn_lo;
      cond[F_PWHI]      = warn_hi;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) o_pressure_used <= '0;
      else o_pressure_used <= (cond[F_PMEAS] || cond[F_PALM]) ? i_p_substitute
                                                            : i_pressure;
   end

   // ************************************
   // Status flags and reported code
   // ************************************
   localparam logic [7:0] CODES [NUM_FLAGS] = '{
      CODE_NEW_START, CODE_PWR_FAIL, CODE_INCONS, CODE_CNT_SUP, CODE_FREQ1, CODE_FREQ2,
      CODE_QMAX, CODE_PMEAS, CODE_PALM, CODE_MEM_CMP, CODE_BRK1, CODE_BRK2, CODE_SUS1,
      CODE_SUS2, CODE_RUNUP, CODE_RUNDN, CODE_VOVF, CODE_PWLO, CODE_PWHI, CODE_CARD,
      CODE_CAL_OPEN, CODE_IVOVF};
   logic [7:0]  code_next;
   vcfm_sev_t   sev_next;
   always_comb begin
      code_next = CODE_NONE;
      sev_next  = VCFM_SEV_NONE;
      for (int i = NUM_FLAGS - 1; i >= 0; i--) begin
         if (cond[i]) begin
            code_next = CODES[i];
            sev_next  = (i <= F_PALM) ? VCFM_SEV_ALARM :
                        (i <= F_PWHI) ? VCFM_SEV_WARNING : VCFM_SEV_MESSAGE;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_flags    <= '0;
         o_code     <= CODE_NONE;
         o_severity <= VCFM_SEV_NONE;
      end else begin
         o_flags    <= cond;
         o_code     <= code_next;
         o_severity <= sev_next;
      end
   end

   // ************************************
   // Checks
   // ************************************
   sequence s_wrap;
      wrap ##1 1'b1;
   endsequence
   AST_WRAP_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_wrap |-> (o_volume == '0)) else $error("volume did not wrap to zero");
   AST_WRAP_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wrap |=> o_flags[F_VOVF]) else $error("wrap flag missing");
   AST_FIX_COPY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bad[0] && !vol_tick) |=> (cp_reg[0] == $past(major))) else $error("copy not repaired");
   AST_NO_AGREE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      none_agree |=> o_flags[F_INCONS] && $stable(cp_reg[0])) else $error("E03 missing");
   AST_PWR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !pwr_ok |-> !o_measure_en ##1 o_flags[F_PWR_FAIL]) else $error("power loss not flagged");
   AST_BRK_OFF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !en1 |=> !o_flags[F_BRK1]) else $error("break flag while disabled");
   AST_CAL_MASK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (cal_open && !psb) |=> !o_flags[F_PMEAS]) else $error("current fault not masked");
   AST_SUP_P: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      psb |=> o_flags[F_PMEAS] && o_severity == VCFM_SEV_ALARM) else $error("supply fault lost");
   AST_NONE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_flags == '0) |-> (o_code == CODE_NONE)) else $error("code not E00");
endmodule : vcfm_monitor

// file: verilog/vcfm_pkg.sv
package vcfm_pkg;
   // ************************************
   // Status codes (decimal code in BCD)
   // ************************************
   localparam logic [7:0] CODE_NONE      = 8'h00;
   localparam logic [7:0] CODE_NEW_START = 8'h01;
   localparam logic [7:0] CODE_PWR_FAIL  = 8'h02;
   localparam logic [7:0] CODE_INCONS    = 8'h03;
   localparam logic [7:0] CODE_MEM_CMP   = 8'h04;
   localparam logic [7:0] CODE_CARD      = 8'h05;
   localparam logic [7:0] CODE_CAL_OPEN  = 8'h06;
   localparam logic [7:0] CODE_CNT_SUP   = 8'h10;
   localparam logic [7:0] CODE_FREQ1     = 8'h11;
   localparam logic [7:0] CODE_FREQ2     = 8'h12;
   localparam logic [7:0] CODE_BRK1      = 8'h13;
   localparam logic [7:0] CODE_BRK2      = 8'h14;
   localparam logic [7:0] CODE_SUS1      = 8'h15;
   localparam logic [7:0] CODE_SUS2      = 8'h16;
   localparam logic [7:0] CODE_QMAX      = 8'h20;
   localparam logic [7:0] CODE_RUNUP     = 8'h22;
   localparam logic [7:0] CODE_RUNDN     = 8'h23;
   localparam logic [7:0] CODE_VOVF      = 8'h24;
   localparam logic [7:0] CODE_IVOVF     = 8'h25;
   localparam logic [7:0] CODE_PMEAS     = 8'h30;
   localparam logic [7:0] CODE_PALM      = 8'h31;
   localparam logic [7:0] CODE_PWLO      = 8'h33;
   localparam logic [7:0] CODE_PWHI      = 8'h34;

   // ************************************
   // Severity classes
   // ************************************
   typedef enum logic [1:0] {
      VCFM_SEV_NONE    = 2'h0,
      VCFM_SEV_MESSAGE = 2'h1,
      VCFM_SEV_WARNING = 2'h2,
      VCFM_SEV_ALARM   = 2'h3
   } vcfm_sev_t;

   // ************************************
   // Flag indices (lower index reported first)
   // ************************************
   localparam int NUM_FLAGS = 22;
   localparam int F_NEW_START = 0;
   localparam int F_PWR_FAIL  = 1;
   localparam int F_INCONS    = 2;
   localparam int F_CNT_SUP   = 3;
   localparam int F_FREQ1     = 4;
   localparam int F_FREQ2     = 5;
   localparam int F_QMAX      = 6;
   localparam int F_PMEAS     = 7;
   localparam int F_PALM      = 8;
   localparam int F_MEM_CMP   = 9;
   localparam int F_BRK1      = 10;
   localparam int F_BRK2      = 11;
   localparam int F_SUS1      = 12;
   localparam int F_SUS2      = 13;
   localparam int F_RUNUP     = 14;
   localparam int F_RUNDN     = 15;
   localparam int F_VOVF      = 16;
   localparam int F_PWLO      = 17;
   localparam int F_PWHI      = 18;
   localparam int F_CARD      = 19;
   localparam int F_CAL_OPEN  = 20;
   localparam int F_IVOVF     = 21;

   // ************************************
   // Limits and counter range
   // ************************************
   localparam int FREQ_LIM_NUM  = 18;   // 1.8 = 18/10
   localparam int FLOW_LIM_NUM  = 11;   // 1.1 = 11/10
   localparam int LIM_DEN       = 10;
   localparam int CUR_MIN_UA    = 3000;  // 3 mA
   localparam int CUR_MAX_UA    = 20200; // 20.2 mA
   localparam logic [31:0] VCNT_MAX   = 32'h05f5e0ff; // 99,999,999
   localparam logic [31:0] VCNT_RESET = 32'h00000000;
   localparam int VCNT_W = 27;
endpackage : vcfm_pkg

// file: verilog/vcfm_vote.sv
module vcfm_vote
   import vcfm_pkg::*;
#(
   parameter int W = 27
) (
   // Three stored copies
   input  wire logic [W-1:0] i_cp0,
   input  wire logic [W-1:0] i_cp1,
   input  wire logic [W-1:0] i_cp2,
   // Vote result
   output logic      [W-1:0] o_major,
   output logic      [2:0]   o_bad,
   output logic              o_none
);
   initial begin
      if (W < 1) $error("vcfm_vote: W must be positive");
   end

   logic e01;
   logic e02;
   logic e12;

   always_comb begin
      e01     = (i_cp0 == i_cp1);
      e02     = (i_cp0 == i_cp2);
      e12     = (i_cp1 == i_cp2);
      o_none  = !e01 && !e02 && !e12;
      o_major = (e01 || e02) ? i_cp0 : i_cp1;
      o_bad   = {e01 && !e02, e02 && !e01, e12 && !e01};
   end
endmodule : vcfm_vote

// file: verif/vcfm_pulse_gen.sv
// ************************************
// Volume pulse generator model
// ************************************
module vcfm_pulse_gen (
   // Clock and burst request
   input  wire logic       i_clk,
   input  wire logic       i_start,
   input  wire logic [7:0] i_num,
   // Pulse line, idles low between bursts
   output logic            o_pulse
);
   timeunit 1ns;
   timeprecision 100ps;

   // Three cycles high, three low: above the two-cycle sync minimum
   initial begin
      o_pulse = 1'h0;
      forever begin
         @(posedge i_clk iff i_start);
         for (int k = 0; k < int'(i_num); k++) begin
            #1 o_pulse = 1'h1;
            repeat (3) @(posedge i_clk);
            #1 o_pulse = 1'h0;
            repeat (3) @(posedge i_clk);
         end
      end
   end
endmodule : vcfm_pulse_gen

// file: verif/tb.sv
module tb
   import vcfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************
   // Signals
   // ************************************
   logic i_clk, i_sys_rst, i_default_params_loaded, i_power_ok, i_param_copy_mismatch;
   logic i_card_addr_fail, i_cal_lock_open, i_ival_ovf, i_pulse_supply_fail, i_pulse1;
   logic i_pulse2, i_line_break1, i_line_break2, i_brk_mon_en1, i_brk_mon_en2, i_p_supply_bad;
   logic [31:0] i_time_now, o_outage_start, o_outage_end;
   logic [15:0] i_freq1, i_freq2, i_freq_qmax, i_flow, i_flow_max, i_lower_flow_limit;
   logic [15:0] i_p_current_ua, i_pressure, i_p_alarm_lo, i_p_alarm_hi, i_p_warn_lo;
   logic [15:0] i_p_warn_hi, i_p_hyst, i_p_substitute, o_pressure_used;
   logic [23:0] i_runup_period, i_rundown_period;
   logic [VCNT_W-1:0] i_dev_limit, o_volume;
   logic [NUM_FLAGS-1:0] o_flags;
   logic [7:0] o_code, n1, n2;
   logic [1:0] o_severity;
   logic o_use_input2, o_measure_en, o_cal_write_en, go1, go2;
   int fails = 0;
   int num_checks = 0;

   vcfm_monitor dut_u (.i_clk, .i_sys_rst, .i_default_params_loaded, .i_power_ok, .i_time_now,
      .i_param_copy_mismatch, .i_card_addr_fail, .i_cal_lock_open, .i_ival_ovf,
      .i_pulse_supply_fail, .i_pulse1, .i_pulse2, .i_line_break1, .i_line_break2,
      .i_brk_mon_en1, .i_brk_mon_en2, .i_freq1, .i_freq2, .i_freq_qmax, .i_dev_limit,
      .i_flow, .i_flow_max, .i_lower_flow_limit, .i_runup_period, .i_rundown_period,
      .i_p_current_ua, .i_p_supply_bad, .i_pressure, .i_p_alarm_lo, .i_p_alarm_hi,
      .i_p_warn_lo, .i_p_warn_hi, .i_p_hyst, .i_p_substitute, .o_flags, .o_code, .o_severity,
      .o_volume, .o_use_input2, .o_measure_en, .o_outage_start, .o_outage_end,
      .o_pressure_used, .o_cal_write_en);
   vcfm_pulse_gen gen1_u (.i_clk(i_clk), .i_start(go1), .i_num(n1), .o_pulse(i_pulse1));
   vcfm_pulse_gen gen2_u (.i_clk(i_clk), .i_start(go2), .i_num(n2), .o_pulse(i_pulse2));

   // ************************************
   // Helpers
   // ************************************
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : step

   task automatic final_report();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_code(input logic [7:0] code);
      int n;
      n = 0;
      while (o_code !== code && n < 20) begin
         step(1);
         n++;
      end
      if (o_code !== code) begin
         fails++;
         final_report();
      end
   endtask : wait_code

   task automatic vals();
      i_time_now = 32'h0; i_freq1 = 16'h0; i_freq2 = 16'h0; i_freq_qmax = 16'h64;
      i_dev_limit = 27'h7ffffff; i_flow = 16'h0; i_flow_max = 16'h64;
      i_lower_flow_limit = 16'h32; i_runup_period = 24'hffffff; i_rundown_period = 24'hffffff;
      i_p_current_ua = 16'h2ee0; i_pressure = 16'h100; i_p_alarm_lo = 16'h10;
      i_p_alarm_hi = 16'h1000; i_p_warn_lo = 16'h64; i_p_warn_hi = 16'h800;
      i_p_hyst = 16'ha; i_p_substitute = 16'h55;
   endtask : vals

   task automatic drive(input int sel, input logic v);
      case (sel)
         0: i_default_params_loaded = v;
         1: i_power_ok = ~v;
         2: i_param_copy_mismatch = v;
         3: i_card_addr_fail = v;
         4: i_cal_lock_open = v;
         5: i_ival_ovf = v;
         6: i_pulse_supply_fail = v;
         7: i_line_break1 = v;
         8: i_line_break2 = v;
         default: i_p_supply_bad = v;
      endcase
   endtask : drive

   // ************************************
   // Scenarios
   // ************************************
   task automatic t_single(input int sel, input logic [7:0] code, input logic [1:0] sev,
                           input int fl);
      drive(sel, 1'h1);
      wait_code(code);
      chk(32'(o_severity), 32'(sev));
      chk(32'(o_flags), 32'(1) << fl);
      chk(32'(o_cal_write_en), 32'(sel == 4));
      chk(32'(o_measure_en), 32'(sel != 1));
      drive(sel, 1'h0);
      wait_code(CODE_NONE);
      chk(32'(o_severity), 32'(VCFM_SEV_NONE));
      $display("single %0d done", sel);
   endtask : t_single

   task automatic lim(input int sel, input logic [15:0] v, input int fl, input logic on);
      case (sel)
         0: i_freq1 = v;
         1: i_freq2 = v;
         2: i_flow = v;
         3: i_p_current_ua = v;
         default: i_pressure = v;
      endcase
      step(4);
      chk(32'(o_flags[fl]), 32'(on));
      if (on && (fl == F_PMEAS || fl == F_PALM))
         chk(32'(o_pressure_used), 32'(i_p_substitute));
      vals();
      step(4);
      $display("limit %0d %h done", sel, v);
   endtask : lim

   task automatic t_brk_off();
      i_brk_mon_en1 = 1'h0;
      i_line_break1 = 1'h1;
      step(8);
      chk(32'(o_flags), 32'h0);
      i_line_break1 = 1'h0;
      i_brk_mon_en1 = 1'h1;
      step(4);
      $display("break off done");
   endtask : t_brk_off

   task automatic t_cal_mask();
      i_cal_lock_open = 1'h1;
      i_p_current_ua = 16'h0bb7;
      step(8);
      chk(32'(o_flags[F_PMEAS]), 32'h0);
      i_p_supply_bad = 1'h1;
      step(8);
      chk(32'(o_flags[F_PMEAS]), 32'h1);
      i_p_supply_bad = 1'h0;
      i_cal_lock_open = 1'h0;
      vals();
      step(8);
      $display("cal mask done");
   endtask : t_cal_mask

   task automatic t_run(input logic [15:0] f0, input logic [15:0] f1, input int fl);
      i_runup_period = 24'ha;
      i_rundown_period = 24'ha;
      i_flow = f0;
      step(4);
      i_flow = f1;
      step(6);
      chk(32'(o_flags[fl]), 32'h0);
      step(10);
      chk(32'(o_flags[fl]), 32'h1);
      vals();
      step(4);
      $display("run %0d done", fl);
   endtask : t_run

   task automatic t_pulses(input logic [7:0] a, input logic [7:0] b);
      n1 = a;
      n2 = b;
      go1 = 1'h1;
      go2 = 1'h1;
      step(1);
      go1 = 1'h0;
      go2 = 1'h0;
      step(6 * 8 + 8);
   endtask : t_pulses

   task automatic t_power();
      i_time_now = 32'h1111;
      i_power_ok = 1'h0;
      step(6);
      chk(32'(o_measure_en), 32'h0);
      t_pulses(8'h3, 8'h0);
      i_time_now = 32'h2222;
      i_power_ok = 1'h1;
      step(6);
      chk(o_outage_start, 32'h1111);
      chk(o_outage_end, 32'h2222);
      chk(32'(o_volume), 32'h5);
      chk(32'(o_measure_en), 32'h1);
      i_time_now = 32'h0;
      $display("power done");
   endtask : t_power

   task automatic t_suspect();
      i_sys_rst = 1'h1;
      step(5);
      i_sys_rst = 1'h0;
      i_dev_limit = 27'h2;
      t_pulses(8'h0, 8'h8);
      chk(32'(o_flags[F_SUS1]), 32'h1);
      chk(32'(o_flags[F_SUS2]), 32'h0);
      chk(32'(o_use_input2), 32'h1);
      $display("suspect done");
   endtask : t_suspect

   // ************************************
   // Clock and main sequence
   // ************************************
   initial begin
      i_clk = 1'h0;
      forever #2 i_clk = ~i_clk;
   end

   initial begin
      {i_default_params_loaded, i_param_copy_mismatch, i_card_addr_fail} = 3'h0;
      {i_cal_lock_open, i_ival_ovf, i_pulse_supply_fail, i_p_supply_bad} = 4'h0;
      {i_line_break1, i_line_break2, go1, go2} = 4'h0;
      {i_power_ok, i_brk_mon_en1, i_brk_mon_en2} = 3'h7;
      n1 = 8'h0;
      n2 = 8'h0;
      vals();
      i_sys_rst = 1'h1;
      step(5);
      i_sys_rst = 1'h0;
      step(1);
      chk(32'(o_code), 32'(CODE_NONE));
      chk(32'(o_flags), 32'h0);
      t_single(0, CODE_NEW_START, VCFM_SEV_ALARM, F_NEW_START);
      t_single(1, CODE_PWR_FAIL, VCFM_SEV_ALARM, F_PWR_FAIL);
      t_single(2, CODE_INCONS, VCFM_SEV_ALARM, F_INCONS);
      t_single(3, CODE_CARD, VCFM_SEV_MESSAGE, F_CARD);
      t_single(4, CODE_CAL_OPEN, VCFM_SEV_MESSAGE, F_CAL_OPEN);
      t_single(5, CODE_IVOVF, VCFM_SEV_MESSAGE, F_IVOVF);
      t_single(6, CODE_CNT_SUP, VCFM_SEV_ALARM, F_CNT_SUP);
      t_single(7, CODE_BRK1, VCFM_SEV_WARNING, F_BRK1);
      t_single(8, CODE_BRK2, VCFM_SEV_WARNING, F_BRK2);
      t_single(9, CODE_PMEAS, VCFM_SEV_ALARM, F_PMEAS);
      t_brk_off();
      lim(0, 16'h00b4, F_FREQ1, 1'h0);
      lim(0, 16'h00b5, F_FREQ1, 1'h1);
      lim(1, 16'h00b5, F_FREQ2, 1'h1);
      lim(2, 16'h006e, F_QMAX, 1'h0);
      lim(2, 16'h006f, F_QMAX, 1'h1);
      lim(3, 16'h0bb7, F_PMEAS, 1'h1);
      lim(3, 16'h0bb8, F_PMEAS, 1'h0);
      lim(3, 16'h4ee8, F_PMEAS, 1'h0);
      lim(3, 16'h4ee9, F_PMEAS, 1'h1);
      lim(4, 16'h000f, F_PALM, 1'h1);
      lim(4, 16'h0010, F_PALM, 1'h0);
      lim(4, 16'h1001, F_PALM, 1'h1);
      lim(4, 16'h005e, F_PWLO, 1'h1);
      lim(4, 16'h005f, F_PWLO, 1'h0);
      lim(4, 16'h0806, F_PWHI, 1'h1);
      lim(4, 16'h0805, F_PWHI, 1'h0);
      t_cal_mask();
      t_run(16'h0000, 16'h0010, F_RUNUP);
      t_run(16'h0040, 16'h0010, F_RUNDN);
      t_pulses(8'h5, 8'h5);
      chk(32'(o_volume), 32'h5);
      t_power();
      t_suspect();
      final_report();
   end
endmodule : tb
